//--- cpuem_pkg.sv
package cpuem_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 10;
	localparam int REP_W = 8;
	// command word layout: [15:13] wait, [12:11] addr mod, [10:8] op, [7:0] repeat
	localparam int CMD_AMOD_HI = 12;
	localparam int CMD_AMOD_LO = 11;
	localparam int CMD_OP_HI = 10;
	localparam int CMD_OP_LO = 8;
	localparam int CMD_REP_HI = 7;
	localparam int CMD_REP_LO = 0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [1:0] AMOD_INC = 2'h2;
	localparam logic [1:0] AMOD_DEC = 2'h3;
	localparam logic [ADDR_W-1:0] STEP_8 = 10'h001;
	localparam logic [ADDR_W-1:0] STEP_16 = 10'h002;
	localparam int BUS_STROBE_CYC = 2;
	typedef enum {CPUEM_CMD, CPUEM_ADDR, CPUEM_DATA, CPUEM_STROBE, CPUEM_NEXT} cpuem_state_t;
endpackage

//--- cpuem_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpuem_bus_if;
	logic start;
	logic wr;
	logic [cpuem_pkg::ADDR_W-1:0] addr;
	logic [cpuem_pkg::DATA_W-1:0] wdata;
	logic done;
	logic [cpuem_pkg::DATA_W-1:0] rdata;
	modport ctl (output start, output wr, output addr, output wdata, input done, input rdata);
	modport drv (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

//--- cpuem_bus_drv.sv
`timescale 1ns/1ps
`default_nettype none
module cpuem_bus_drv (
	input wire logic clk,
	input wire logic rst_b,
	cpuem_bus_if.drv bus,
	output logic [cpuem_pkg::ADDR_W-1:0] per_addr,
	output logic [cpuem_pkg::DATA_W-1:0] per_wdata,
	output logic per_wr_b,
	output logic per_rd_b,
	input wire logic [cpuem_pkg::DATA_W-1:0] per_rdata
);
	logic [1:0] cnt_reg;
	logic busy_reg;
	logic tail_reg;
	logic wr_reg;
	logic [cpuem_pkg::DATA_W-1:0] rd_reg;
	logic [cpuem_pkg::DATA_W-1:0] rd_s1_reg;
	wire last_cyc = busy_reg && (cnt_reg == 2'(cpuem_pkg::BUS_STROBE_CYC - 1));
	assign per_wr_b = !(busy_reg && wr_reg);
	assign per_rd_b = !(busy_reg && !wr_reg);
	// done waits one cycle past the strobe so the two sync flops hold the read value
	assign bus.done = tail_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			tail_reg <= 1'b0;
		else
			tail_reg <= last_cyc;
	end
	assign bus.rdata = rd_reg;
	// read data from pins is resynchronised before use
	always_ff @(posedge clk)
	begin
		rd_s1_reg <= per_rdata;
		rd_reg <= rd_s1_reg;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 2'h0;
			wr_reg <= 1'b0;
			per_addr <= '0;
			per_wdata <= '0;
		end
		else if (bus.start && !busy_reg)
		begin
			busy_reg <= 1'b1;
			cnt_reg <= 2'h0;
			wr_reg <= bus.wr;
			per_addr <= bus.addr;
			per_wdata <= bus.wdata;
		end
		else if (last_cyc)
			busy_reg <= 1'b0;
		else if (busy_reg)
			cnt_reg <= cnt_reg + 2'h1;
	end
endmodule // cpuem_bus_drv
`default_nettype wire

//--- cpuem_interp.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - address modification 0x keeps address fixed for all repeats
// R2 - mode 10 adds step, mode 11 subtracts; step one or two by width
// R3 - modification applied between repeats only when repeat count nonzero
// R4 - op 001 writes, op 010 reads the peripheral bus
// R5 - repeat count N executes the operation N plus one times
// R6 - first process drives the command's starting address
// R7 - sixteen-bit mode forces address bit zero low
// R8 - write command is followed by one data word per process
// R9 - stacked command groups run one after another through the block
// R10 - reception-complete status set after whole block processed
// R11 - sender keeps each command group within 256 bytes
// R12 - sender splits data into smaller transfers on noisy long lines
// R13 - word after final repetition is taken as a new command
module cpuem_interp (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic host16,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [cpuem_pkg::DATA_W-1:0] in_word,
	input wire logic in_last,
	output logic rd_valid,
	output logic [cpuem_pkg::DATA_W-1:0] rd_data,
	output logic rx_done,
	input wire logic rx_done_clr,
	output logic [cpuem_pkg::ADDR_W-1:0] per_addr,
	output logic [cpuem_pkg::DATA_W-1:0] per_wdata,
	output logic per_wr_b,
	output logic per_rd_b,
	input wire logic [cpuem_pkg::DATA_W-1:0] per_rdata
);
	cpuem_bus_if bus ();
	cpuem_bus_drv u_drv (
		.clk(clk),
		.rst_b(rst_b),
		.bus(bus),
		.per_addr(per_addr),
		.per_wdata(per_wdata),
		.per_wr_b(per_wr_b),
		.per_rd_b(per_rd_b),
		.per_rdata(per_rdata)
	);
	cpuem_pkg::cpuem_state_t state_reg, state_next;
	logic [1:0] amod_reg;
	logic [2:0] op_reg;
	logic [cpuem_pkg::REP_W-1:0] rep_reg;
	logic [cpuem_pkg::ADDR_W-1:0] addr_reg;
	logic [cpuem_pkg::DATA_W-1:0] wdata_reg;
	logic last_reg;
	logic start_reg;
	// unknown op codes are skipped but their repeats still take one cycle each in CPUEM_NEXT
	wire is_wr = (op_reg == cpuem_pkg::OP_WRITE);
	wire is_rd = (op_reg == cpuem_pkg::OP_READ);
	wire take = in_valid && in_ready;
	wire [cpuem_pkg::ADDR_W-1:0] step = host16 ? cpuem_pkg::STEP_16 : cpuem_pkg::STEP_8; // [R2]
	wire [cpuem_pkg::ADDR_W-1:0] addr_inc = addr_reg + step; // [R2]
	wire [cpuem_pkg::ADDR_W-1:0] addr_dec = addr_reg - step; // [R2]
	wire amod_on = amod_reg[1]; // [R1]
	wire [cpuem_pkg::ADDR_W-1:0] addr_mod = !amod_on ? addr_reg :
		(amod_reg == cpuem_pkg::AMOD_INC) ? addr_inc : addr_dec; // [R1] [R2]
	wire [cpuem_pkg::ADDR_W-1:0] start_addr =
		in_word[cpuem_pkg::ADDR_W-1:0] & ~{{(cpuem_pkg::ADDR_W-1){1'b0}}, host16}; // [R6] [R7]
	wire final_rep = (rep_reg == '0);
	assign in_ready = (state_reg == cpuem_pkg::CPUEM_CMD) || (state_reg == cpuem_pkg::CPUEM_ADDR)
		|| (state_reg == cpuem_pkg::CPUEM_DATA);
	assign bus.start = start_reg;
	assign bus.wr = is_wr;
	assign bus.addr = addr_reg;
	assign bus.wdata = wdata_reg;
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			cpuem_pkg::CPUEM_CMD: if (take) state_next = cpuem_pkg::CPUEM_ADDR;
			cpuem_pkg::CPUEM_ADDR:
				if (take)
					state_next = is_wr ? cpuem_pkg::CPUEM_DATA :
						is_rd ? cpuem_pkg::CPUEM_STROBE : cpuem_pkg::CPUEM_NEXT;
			cpuem_pkg::CPUEM_DATA: if (take) state_next = cpuem_pkg::CPUEM_STROBE; // [R8]
			cpuem_pkg::CPUEM_STROBE: if (bus.done) state_next = cpuem_pkg::CPUEM_NEXT;
			cpuem_pkg::CPUEM_NEXT:
				if (!final_rep)
					state_next = is_wr ? cpuem_pkg::CPUEM_DATA :
						is_rd ? cpuem_pkg::CPUEM_STROBE : cpuem_pkg::CPUEM_NEXT; // [R5]
				else
					state_next = cpuem_pkg::CPUEM_CMD; // [R13] [R9]
			default: state_next = cpuem_pkg::CPUEM_CMD;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			state_reg <= cpuem_pkg::CPUEM_CMD;
		else
			state_reg <= state_next;
	end
	// command fields: word 0 is mode/op/repeat, word 1 the starting address
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			amod_reg <= 2'h0;
			op_reg <= 3'h0;
			rep_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			last_reg <= 1'b0;
		end
		else
		begin
			if (take && state_reg == cpuem_pkg::CPUEM_CMD)
			begin
				amod_reg <= in_word[cpuem_pkg::CMD_AMOD_HI:cpuem_pkg::CMD_AMOD_LO];
				op_reg <= in_word[cpuem_pkg::CMD_OP_HI:cpuem_pkg::CMD_OP_LO]; // [R4]
				rep_reg <= in_word[cpuem_pkg::CMD_REP_HI:cpuem_pkg::CMD_REP_LO]; // [R5]
			end
			if (take && state_reg == cpuem_pkg::CPUEM_ADDR)
				addr_reg <= start_addr; // [R6]
			if (take && state_reg == cpuem_pkg::CPUEM_DATA)
				wdata_reg <= in_word; // [R8]
			if (take)
				last_reg <= in_last;
			if (state_reg == cpuem_pkg::CPUEM_NEXT && !final_rep)
			begin
				rep_reg <= rep_reg - 1'b1; // [R5]
				addr_reg <= addr_mod; // [R3]
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			start_reg <= 1'b0;
		else
			start_reg <= (state_next == cpuem_pkg::CPUEM_STROBE) && !start_reg
				&& (state_reg != cpuem_pkg::CPUEM_STROBE); // [R4]
	end
	// read results are returned as a one-cycle stream; no buffering
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rd_valid <= bus.done && !is_wr; // [R4]
			if (bus.done && !is_wr)
				rd_data <= bus.rdata;
		end
	end
	// set wins over clear so a finishing block is never lost
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rx_done <= 1'b0;
		else if (state_reg == cpuem_pkg::CPUEM_NEXT && final_rep && last_reg)
			rx_done <= 1'b1; // [R10] [R9]
		else if (rx_done_clr)
			rx_done <= 1'b0;
	end
	chk_fixed_addr_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == cpuem_pkg::CPUEM_NEXT && !final_rep && !amod_on)
		|=> $stable(addr_reg)) else $error("address moved in fixed mode"); // [R1]
	chk_inc_step: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == cpuem_pkg::CPUEM_NEXT && !final_rep && amod_reg == cpuem_pkg::AMOD_INC)
		|=> addr_reg == $past(addr_reg) + (host16 ? cpuem_pkg::STEP_16 : cpuem_pkg::STEP_8))
		else $error("bad increment step"); // [R2]
	chk_dec_step: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == cpuem_pkg::CPUEM_NEXT && !final_rep && amod_reg == cpuem_pkg::AMOD_DEC)
		|=> addr_reg == $past(addr_reg) - (host16 ? cpuem_pkg::STEP_16 : cpuem_pkg::STEP_8))
		else $error("bad decrement step"); // [R2]
	chk_last_no_mod: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == cpuem_pkg::CPUEM_NEXT && final_rep) |=> $stable(addr_reg)
		&& state_reg == cpuem_pkg::CPUEM_CMD) else $error("modified after last"); // [R3] [R13]
	chk_write_strobe: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.start && is_wr) |=> !per_wr_b && per_rd_b) else $error("write strobe missing"); // [R4]
	chk_start_addr: assert property (@(posedge clk) disable iff (!rst_b)
		(take && state_reg == cpuem_pkg::CPUEM_ADDR) |=> addr_reg == $past(start_addr))
		else $error("start address not loaded"); // [R6]
	chk_lsb_zero16: assert property (@(posedge clk) disable iff (!rst_b)
		(host16 && $past(host16) && !per_wr_b) |-> !per_addr[0])
		else $error("lsb driven in 16-bit mode"); // [R7]
	chk_wdata_used: assert property (@(posedge clk) disable iff (!rst_b)
		(take && state_reg == cpuem_pkg::CPUEM_DATA) |=> ##1 per_wdata == $past(in_word, 2))
		else $error("write data not forwarded"); // [R8]
	chk_done_flag: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == cpuem_pkg::CPUEM_NEXT && final_rep && last_reg) |=> rx_done)
		else $error("complete bit not set"); // [R10]
endmodule // cpuem_interp
`default_nettype wire

//--- cpuem_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpuem_periph_model (
	input wire logic clk,
	input wire logic [cpuem_pkg::ADDR_W-1:0] per_addr,
	input wire logic [cpuem_pkg::DATA_W-1:0] per_wdata,
	input wire logic per_wr_b,
	input wire logic per_rd_b,
	output logic [cpuem_pkg::DATA_W-1:0] per_rdata
);
	logic [cpuem_pkg::DATA_W-1:0] mem [0:1023];
	logic [cpuem_pkg::DATA_W-1:0] junk_reg = 16'h5a5a;
	// released bus toggles so a late sample never looks right
	always @(posedge clk)
	begin
		junk_reg <= ~junk_reg;
		if (per_wr_b === 1'b0)
			mem[per_addr] <= per_wdata;
	end
	assign per_rdata = (per_rd_b === 1'b0) ? mem[per_addr] : junk_reg;
endmodule // cpuem_periph_model
`default_nettype wire

//--- cpu_emulation_command_interp_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_emulation_command_interp_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic host16 = 1'b0;
	logic in_valid = 1'b0;
	logic in_last = 1'b0;
	logic rx_done_clr = 1'b0;
	logic [15:0] in_word = 16'h0000;
	logic in_ready, rd_valid, rx_done, per_wr_b, per_rd_b;
	logic [15:0] rd_data, per_wdata, per_rdata;
	logic [9:0] per_addr;
	int fail_count = 0;
	int num_checks = 0;
	logic [15:0] exp_mem [0:1023];
	logic [15:0] rd_q [$];
	logic [9:0] wa_q [$];
	always #4 clk = ~clk;
	cpuem_interp dut (.clk, .rst_b, .host16, .in_valid, .in_ready, .in_word, .in_last,
		.rd_valid, .rd_data, .rx_done, .rx_done_clr, .per_addr, .per_wdata, .per_wr_b,
		.per_rd_b, .per_rdata);
	cpuem_periph_model pm (.clk, .per_addr, .per_wdata, .per_wr_b, .per_rd_b, .per_rdata);
	always @(posedge clk)
	begin
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);
		if ($fell(per_wr_b))
			wa_q.push_back(per_addr);
	end
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask
	// valid stays up between words so it is never assigned twice in one step
	task automatic send(input logic [15:0] w, input logic l);
		int n;
		in_valid <= 1'b1;
		in_word <= w;
		in_last <= l;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (in_ready !== 1'b1 && n < 100);
	endtask
	function automatic logic [9:0] paddr(logic [9:0] a, logic [1:0] m, logic h, int i);
		logic [9:0] b;
		logic [9:0] s;
		b = h ? {a[9:1], 1'b0} : a;
		s = h ? 10'h002 : 10'h001;
		if (m == 2'h2)
			return b + 10'(i) * s;
		if (m == 2'h3)
			return b - 10'(i) * s;
		return b;
	endfunction
	initial
	begin
		#400000;
		fail_count++;
		test_done();
	end
	initial
	begin
		logic [9:0] a, p;
		logic [1:0] m;
		logic [7:0] r;
		logic [15:0] d;
		logic h;
		int n;
		void'($urandom(32'h3de8));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 24; k++)
		begin
			h = k[0];
			m = 2'(k >> 1);
			r = (k < 4) ? 8'h00 : 8'($urandom_range(7));
			a = (k == 7) ? 10'h001 : 10'($urandom);
			rd_q.delete();
			wa_q.delete();
			host16 <= h;
			send({3'h0, m, 3'h1, r}, 1'b0); // groups stay at most ten words, 20 bytes
			send({6'h00, a}, 1'b0);
			for (int i = 0; i <= r; i++)
			begin
				d = 16'($urandom);
				exp_mem[paddr(a, m, h, i)] = d;
				send(d, 1'b0);
			end
			// undefined op with repeats must make no bus cycle at all
			send({3'h0, m, 3'h4, 8'h02}, 1'b0);
			send({6'h00, ~a}, 1'b0);
			send({3'h0, m, 3'h2, r}, 1'b0);
			send({6'h00, a}, 1'b1);
			in_valid <= 1'b0;
			n = 0;
			while (rx_done !== 1'b1 && n < 3000)
			begin
				@(posedge clk);
				n++;
			end
			check(n < 3000, "completion flag missing");
			repeat (12) @(posedge clk);
			check(rd_q.size() == r + 1 && wa_q.size() == r + 1, "process count");
			for (int i = 0; i <= r; i++)
			begin
				p = paddr(a, m, h, i);
				check(i < wa_q.size() && wa_q[i] === p, "write address");
				check(pm.mem[p] === exp_mem[p], "write data");
				check(i < rd_q.size() && rd_q[i] === exp_mem[p], "read data");
			end
			rx_done_clr <= 1'b1;
			@(posedge clk);
			rx_done_clr <= 1'b0;
			@(posedge clk);
			check(rx_done === 1'b0, "completion flag stuck");
		end
		test_done();
	end
endmodule // cpu_emulation_command_interp_test
`default_nettype wire
